// *** verilog/ssc_sequencer.sv ***
/*
  first eight-step sample sequencer: step control, converter requests,
  result fifo and interrupt status, behind an avalon-mm slave with waitrequest.
  assumes the converter raises conv_done for one cycle with conv_data valid,
  no earlier than the cycle after conv_req.start, once per request.
*/
// Design decision made here: the Avalon-MM slave port.
// Functional notes
// RULE1 - step control register is 32 bits, four control bits for each of eight steps
// RULE2 - step n uses bits 4n+3..4n: temp, irq enable, end marker, differential
// RULE3 - temp bit set converts the sensor, else the pin from the step's mux field
// RULE4 - a step with irq enable raises the raw irq when its conversion completes
// RULE5 - raw irq reaches the interrupt output only while its mask bit is set
// RULE6 - any number of steps may raise the raw irq within one sequence
// RULE7 - the step with end marker set is the last one converted
// RULE8 - software sets an end marker on at least one step
// RULE9 - a single-step sequencer always ends after its first step
// RULE10 - differential bit samples pair i, inputs 2i and 2i+1
// RULE11 - a temperature sensor step is always single-ended
// RULE12 - each result read pops the oldest result, in step order
// RULE13 - push into full fifo flags overflow, read of empty fifo flags underflow
// RULE14 - result in bits 9:0, upper bits read as zero
// RULE15 - mux field value selects the analog input of that index
// RULE16 - fifo status shows full, empty, head and tail; resets to 0x100
// RULE17 - writing one to the trigger bit starts sampling if the sequencer is active
// RULE18 - steps run from 0 upward, one at a time, result stored before next
`timescale 1ns/10ps
`default_nettype none

module ssc_sequencer #(
  parameter int unsigned STEPS = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst,
  // avalon-mm slave
  input  wire logic [7:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [3:0]                     avs_byteenable,
  input  wire logic [31:0]                    avs_writedata,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  // converter
  output ssc_pkg::ssc_conv_req_s              conv_req,
  input  wire logic                           conv_done,
  input  wire logic [ssc_pkg::RESULT_W-1:0]   conv_data,
  // interrupt
  output logic                                irq
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = DEPTH[PW:0];
  localparam logic [2:0]  LAST_STEP = 3'(STEPS - 1);

  typedef struct packed {
    ssc_pkg::ssc_seq_e                         seq;
    logic [2:0]                                step;
    logic                                      active;
    logic [31:0]                               ctl;
    logic [31:0]                               mux;
    logic [ssc_pkg::IRQ_W-1:0]                 status;
    logic [ssc_pkg::IRQ_W-1:0]                 mask;
    logic [DEPTH-1:0][ssc_pkg::RESULT_W-1:0]   mem;
    logic [PW-1:0]                             head;
    logic [PW-1:0]                             tail;
    logic [PW:0]                               count;
    logic                                      wait_q;
    logic [31:0]                               rdata;
    logic                                      irq;
    ssc_pkg::ssc_conv_req_s                    conv;
  } ssc_state_s;

  ssc_state_s s_q;
  ssc_state_s s_d;

  logic                          acc;
  logic                          wr;
  logic                          rd;
  logic                          trig;
  logic                          push;
  logic                          pop;
  logic                          ovf_ev;
  logic                          unf_ev;
  logic                          raw_ev;
  logic                          fifo_full;
  logic                          fifo_empty;
  logic [ssc_pkg::STEP_BITS-1:0] fld;
  logic [ssc_pkg::IRQ_W-1:0]     clr;
  logic [31:0]                   fstat;
  logic [31:0]                   mask_w;

  // control nibble of one step
  function automatic logic [ssc_pkg::STEP_BITS-1:0] step_field(
    input logic [31:0] ctl,
    input logic [2:0]  idx
  );
    step_field = ctl[idx*ssc_pkg::STEP_BITS +: ssc_pkg::STEP_BITS]; // [RULE2]
  endfunction : step_field

  // input index of one step
  function automatic logic [ssc_pkg::MUX_FLD_W-1:0] mux_field(
    input logic [31:0] mux,
    input logic [2:0]  idx
  );
    mux_field = mux[idx*ssc_pkg::STEP_BITS +: ssc_pkg::MUX_FLD_W];
  endfunction : mux_field

  // byte-lane write merge
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0]  be
  );
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
  endfunction : be_merge

  always_comb begin
    s_d        = s_q;
    acc        = (avs_read | avs_write) & s_q.wait_q;
    wr         = acc & avs_write;
    rd         = acc & avs_read;
    trig       = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    ovf_ev     = 1'b0;
    unf_ev     = 1'b0;
    raw_ev     = 1'b0;
    clr        = '0;
    fifo_full  = (s_q.count == DEPTH_CNT);
    fifo_empty = (s_q.count == '0);
    fld        = step_field(s_q.ctl, s_q.step);
    fstat      = '0;
    mask_w     = be_merge({29'h0, s_q.mask}, avs_writedata, avs_byteenable);
    fstat[ssc_pkg::FSTAT_FULL]  = fifo_full; // [RULE16]
    fstat[ssc_pkg::FSTAT_EMPTY] = fifo_empty;
    fstat[ssc_pkg::FSTAT_HEAD_LSB +: PW] = s_q.head;
    fstat[ssc_pkg::FSTAT_TAIL_LSB +: PW] = s_q.tail;
    s_d.conv.start = 1'b0;
    // waitrequest drops for exactly one cycle per access
    s_d.wait_q = ~acc;

    if (wr) begin
      unique case (avs_address)
        ssc_pkg::OFF_ACTIVE:     s_d.active = avs_byteenable[0] & avs_writedata[0] |
                                              ~avs_byteenable[0] & s_q.active;
        ssc_pkg::OFF_IRQ_STATUS: clr = avs_writedata[ssc_pkg::IRQ_W-1:0] &
                                       {ssc_pkg::IRQ_W{avs_byteenable[0]}};
        ssc_pkg::OFF_IRQ_MASK:   s_d.mask = mask_w[ssc_pkg::IRQ_W-1:0]; // [RULE5]
        ssc_pkg::OFF_TRIGGER:    trig = avs_byteenable[0] & avs_writedata[0]; // [RULE17]
        ssc_pkg::OFF_INPUT_SEL:  s_d.mux = be_merge(s_q.mux, avs_writedata, avs_byteenable);
        ssc_pkg::OFF_STEP_CTL:   s_d.ctl = be_merge(s_q.ctl, avs_writedata,
                                                    avs_byteenable); // [RULE1]
        default: ;
      endcase
    end

    if (rd) begin
      unique case (avs_address)
        ssc_pkg::OFF_ACTIVE:     s_d.rdata = {31'h0, s_q.active};
        ssc_pkg::OFF_IRQ_STATUS: s_d.rdata = {29'h0, s_q.status};
        ssc_pkg::OFF_IRQ_MASK:   s_d.rdata = {29'h0, s_q.mask};
        ssc_pkg::OFF_INPUT_SEL:  s_d.rdata = s_q.mux;
        ssc_pkg::OFF_STEP_CTL:   s_d.rdata = s_q.ctl;
        ssc_pkg::OFF_FIFO_STAT:  s_d.rdata = fstat;
        ssc_pkg::OFF_RESULT: begin
          if (fifo_empty) begin
            unf_ev    = 1'b1; // [RULE13]
            s_d.rdata = '0;
          end else begin
            pop       = 1'b1; // [RULE12]
            s_d.rdata = {22'h0, s_q.mem[s_q.tail]}; // [RULE14]
          end
        end
        default:                 s_d.rdata = '0;
      endcase
    end

    unique case (s_q.seq)
      ssc_pkg::SSC_IDLE: begin
        if (trig && s_q.active) begin
          s_d.seq  = ssc_pkg::SSC_REQ; // [RULE17]
          s_d.step = 3'h0; // [RULE18]
        end
      end
      ssc_pkg::SSC_REQ: begin
        s_d.conv.start   = 1'b1;
        s_d.conv.temp    = fld[ssc_pkg::FLD_TS]; // [RULE3]
        s_d.conv.diff    = fld[ssc_pkg::FLD_DIFF] & ~fld[ssc_pkg::FLD_TS]; // [RULE10] [RULE11]
        s_d.conv.channel = mux_field(s_q.mux, s_q.step); // [RULE15]
        s_d.seq          = ssc_pkg::SSC_WAIT;
      end
      ssc_pkg::SSC_WAIT: begin
        if (conv_done) begin
          push   = 1'b1; // [RULE18]
          raw_ev = fld[ssc_pkg::FLD_IE]; // [RULE4] [RULE6]
          // last step always ends, so a missing end marker cannot run away
          if (fld[ssc_pkg::FLD_END] || s_q.step == LAST_STEP) begin
            s_d.seq = ssc_pkg::SSC_IDLE; // [RULE7] [RULE8] [RULE9]
          end else begin
            s_d.step = s_q.step + 3'h1;
            s_d.seq  = ssc_pkg::SSC_REQ;
          end
        end
      end
    endcase

    // result fifo; a push into a full fifo is dropped
    if (push) begin
      if (fifo_full) begin
        ovf_ev = 1'b1; // [RULE13]
      end else begin
        s_d.mem[s_q.head] = conv_data;
        s_d.head          = s_q.head + 1'b1;
      end
    end
    if (pop) begin
      s_d.tail = s_q.tail + 1'b1;
    end
    s_d.count = s_q.count + (PW + 1)'(push & ~fifo_full) - (PW + 1)'(pop);

    // sticky status, set wins over write-one clear
    s_d.status = (s_q.status & ~clr) | {unf_ev, ovf_ev, raw_ev};
    s_d.irq    = |(s_d.status & s_d.mask); // [RULE5]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.ctl    <= ssc_pkg::CTL_RST;
      s_q.wait_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wait_q;
  assign conv_req        = s_q.conv;
  assign irq             = s_q.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence trig_start_seq;
    ##1 (s_q.seq == ssc_pkg::SSC_REQ && s_q.step == 3'h0) ##1 conv_req.start;
  endsequence

  sequence next_step_seq;
    ##1 (s_q.seq == ssc_pkg::SSC_REQ && s_q.step == $past(s_q.step) + 3'h1)
    ##1 conv_req.start;
  endsequence

  chk_trigger_start: // [RULE17]
    assert property (trig && s_q.active && s_q.seq == ssc_pkg::SSC_IDLE |-> trig_start_seq)
      else $error("trigger did not start step 0");
  chk_idle_no_trig: // [RULE17]
    assert property (trig && !s_q.active && s_q.seq == ssc_pkg::SSC_IDLE
                     |=> s_q.seq == ssc_pkg::SSC_IDLE [*2])
      else $error("inactive sequencer started");
  chk_conv_fields: // [RULE3]
    assert property (conv_req.start |-> conv_req.temp == fld[ssc_pkg::FLD_TS] &&
                     conv_req.channel == mux_field(s_q.mux, s_q.step))
      else $error("converter request fields differ from step control");
  chk_temp_single: // [RULE11]
    assert property (conv_req.start && conv_req.temp |-> !conv_req.diff)
      else $error("temperature step requested differential");
  chk_step_irq: // [RULE4]
    assert property (s_q.seq == ssc_pkg::SSC_WAIT && conv_done && fld[ssc_pkg::FLD_IE]
                     |=> s_q.status[ssc_pkg::IRQ_RAW])
      else $error("step irq not raised");
  chk_irq_mask: // [RULE5]
    assert property (irq == |(s_q.status & s_q.mask))
      else $error("interrupt output disagrees with status and mask");
  chk_end_stops: // [RULE7]
    assert property (s_q.seq == ssc_pkg::SSC_WAIT && conv_done && fld[ssc_pkg::FLD_END]
                     |=> s_q.seq == ssc_pkg::SSC_IDLE && !conv_req.start)
      else $error("sequence ran past end marker");
  chk_step_order: // [RULE18]
    assert property (s_q.seq == ssc_pkg::SSC_WAIT && conv_done && !fld[ssc_pkg::FLD_END] &&
                     s_q.step != LAST_STEP |-> next_step_seq)
      else $error("steps not taken in order");
  chk_overflow_flag: // [RULE13]
    assert property (push && fifo_full |=> s_q.status[ssc_pkg::IRQ_OVF] && s_q.count == DEPTH_CNT)
      else $error("overflow not flagged");
  chk_underflow_flag: // [RULE13]
    assert property (rd && avs_address == ssc_pkg::OFF_RESULT && fifo_empty
                     |=> s_q.status[ssc_pkg::IRQ_UNF])
      else $error("underflow not flagged");
  chk_pop_oldest: // [RULE12]
    assert property (rd && avs_address == ssc_pkg::OFF_RESULT && !fifo_empty
                     |=> avs_readdata[ssc_pkg::RESULT_W-1:0] == $past(s_q.mem[s_q.tail]) &&
                         s_q.tail == $past(s_q.tail) + 1'b1)
      else $error("fifo read did not pop oldest result");

endmodule : ssc_sequencer

`default_nettype wire

// *** verilog/ssc_pkg.sv ***
/*
  shared constants and carrier types of the sample sequence control block.
  assumes a 32-bit register bus with byte addresses and word-aligned registers.
*/
`default_nettype none

package ssc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_ACTIVE     = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h08;
  localparam logic [7:0] OFF_TRIGGER    = 8'h28;
  localparam logic [7:0] OFF_INPUT_SEL  = 8'h40;
  localparam logic [7:0] OFF_STEP_CTL   = 8'h44;
  localparam logic [7:0] OFF_RESULT     = 8'h48;
  localparam logic [7:0] OFF_FIFO_STAT  = 8'h4C;

  // per-step control nibble layout
  localparam int unsigned STEP_BITS = 4;
  localparam int unsigned FLD_DIFF  = 0;
  localparam int unsigned FLD_END   = 1;
  localparam int unsigned FLD_IE    = 2;
  localparam int unsigned FLD_TS    = 3;
  localparam int unsigned MUX_FLD_W = 2;

  // interrupt status and mask bits
  localparam int unsigned IRQ_W   = 3;
  localparam int unsigned IRQ_RAW = 0;
  localparam int unsigned IRQ_OVF = 1;
  localparam int unsigned IRQ_UNF = 2;

  // fifo status layout
  localparam int unsigned FSTAT_TAIL_LSB = 0;
  localparam int unsigned FSTAT_HEAD_LSB = 4;
  localparam int unsigned FSTAT_EMPTY    = 8;
  localparam int unsigned FSTAT_FULL     = 12;

  // result and reset values
  localparam int unsigned RESULT_W      = 10;
  localparam logic [31:0] CTL_RST       = 32'h0000_0000;
  localparam logic [31:0] FIFO_STAT_RST = 32'h0000_0100;

  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_REQ,
    SSC_WAIT
  } ssc_seq_e;

  // request to the converter and its input multiplexer
  typedef struct packed {
    logic                 start;
    logic                 temp;
    logic                 diff;
    logic [MUX_FLD_W-1:0] channel;
  } ssc_conv_req_s;

endpackage : ssc_pkg

`default_nettype wire

// *** testbench/ssc_conv_model.sv ***
/*
  behavioural converter for the sequencer bench: answers each start pulse
  after one cycle, or five when slow is high. assumes one request at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module ssc_conv_model (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // request side
  input  wire ssc_pkg::ssc_conv_req_s  conv_req,
  input  wire logic                    slow,
  // answer side
  output logic                         conv_done,
  output logic [9:0]                   conv_data,
  output logic [7:0]                   served
);
  logic       busy;
  logic [2:0] cnt;
  logic [9:0] res;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy      <= 1'b0;
      cnt       <= 3'h0;
      res       <= 10'h000;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
      served    <= 8'h00;
    end else begin
      conv_done <= 1'b0;
      // data not valid outside the done pulse
      conv_data <= ~conv_data;
      if (conv_req.start) begin
        busy <= 1'b1;
        cnt  <= slow ? 3'h5 : 3'h1;
        res  <= {served[4:0], conv_req.temp, conv_req.diff, 1'b0, conv_req.channel};
      end else if (busy) begin
        if (cnt == 3'h1) begin
          conv_done <= 1'b1;
          conv_data <= res;
          busy      <= 1'b0;
          served    <= served + 8'h01;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end
    end
  end
endmodule : ssc_conv_model
`default_nettype wire

// *** testbench/sample_sequence_control_fifo_bench.sv ***
/*
  self-checking bench of the sequencer: register bus tasks and scenarios.
  assumes ssc_pkg, ssc_sequencer and ssc_conv_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module sample_sequence_control_fifo_bench;
  logic                   clock, rst, avs_read, avs_write, avs_waitrequest;
  logic                   conv_done, irq, slow;
  logic [7:0]             avs_address, served, base;
  logic [31:0]            avs_writedata, avs_readdata, rd;
  logic [9:0]             conv_data;
  ssc_pkg::ssc_conv_req_s conv_req;
  int                     failures, cmp_count;

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ssc_sequencer i_ssc_sequencer (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data), .irq(irq));
  ssc_conv_model i_ssc_conv_model (.clock(clock), .rst(rst), .conv_req(conv_req),
    .slow(slow), .conv_done(conv_done), .conv_data(conv_data), .served(served));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon access; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      tally_and_finish;
    end
    // taken at the edge where waitrequest is low, released right after it
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wait_served(input logic [7:0] t);
    int n;
    n = 0;
    while (served !== t && n < 500) begin
      @(posedge clock);
      n++;
    end
    if (served !== t) begin
      failures++;
      tally_and_finish;
    end
    repeat (12) @(posedge clock);
    check(served, t);
  endtask : wait_served

  function automatic logic [31:0] res(input logic [7:0] n, input logic t, input logic d,
                                      input logic [1:0] ch);
    return {22'h0, n[4:0], t, d & ~t, 1'b0, ch};
  endfunction : res

  task t_reset;
    bus(1'b0, ssc_pkg::OFF_FIFO_STAT, 32'h0);
    check(rd, ssc_pkg::FIFO_STAT_RST);
    bus(1'b0, ssc_pkg::OFF_STEP_CTL, 32'h0);
    check(rd, ssc_pkg::CTL_RST);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, ssc_pkg::OFF_RESULT, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, ssc_pkg::OFF_IRQ_STATUS, 32'h0);
    check(rd, 32'h4);
    bus(1'b1, ssc_pkg::OFF_IRQ_STATUS, 32'h7);
    bus(1'b0, ssc_pkg::OFF_IRQ_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, ssc_pkg::OFF_TRIGGER, 32'h1);
    repeat (20) @(posedge clock);
    check(served, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task t_seq;
    base = served;
    bus(1'b1, ssc_pkg::OFF_ACTIVE, 32'h1);
    bus(1'b1, ssc_pkg::OFF_IRQ_MASK, 32'h0);
    bus(1'b1, ssc_pkg::OFF_INPUT_SEL, 32'h0000_0321);
    bus(1'b1, ssc_pkg::OFF_STEP_CTL, 32'hF1F0_FF14);
    bus(1'b0, ssc_pkg::OFF_STEP_CTL, 32'h0);
    check(rd, 32'hF1F0_FF14);
    bus(1'b0, ssc_pkg::OFF_INPUT_SEL, 32'h0);
    check(rd, 32'h0000_0321);
    bus(1'b0, ssc_pkg::OFF_ACTIVE, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, ssc_pkg::OFF_TRIGGER, 32'h1);
    wait_served(base + 8'h03);
    bus(1'b0, ssc_pkg::OFF_RESULT, 32'h0);
    check(rd, res(base, 1'b0, 1'b0, 2'h1));
    bus(1'b0, ssc_pkg::OFF_RESULT, 32'h0);
    check(rd, res(base + 8'h01, 1'b0, 1'b1, 2'h2));
    bus(1'b0, ssc_pkg::OFF_RESULT, 32'h0);
    check(rd, res(base + 8'h02, 1'b1, 1'b1, 2'h3));
    bus(1'b0, ssc_pkg::OFF_IRQ_STATUS, 32'h0);
    check(rd, 32'h1);
    check(irq, 32'h0);
    bus(1'b1, ssc_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 32'h1);
    bus(1'b0, ssc_pkg::OFF_IRQ_MASK, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, ssc_pkg::OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    check(irq, 32'h0);
    $display("test sequence done");
  endtask : t_seq

  task t_full;
    base = served;
    slow <= 1'b1;
    bus(1'b1, ssc_pkg::OFF_INPUT_SEL, 32'h0);
    bus(1'b1, ssc_pkg::OFF_STEP_CTL, 32'h2000_0000);
    bus(1'b1, ssc_pkg::OFF_TRIGGER, 32'h1);
    wait_served(base + 8'h08);
    bus(1'b0, ssc_pkg::OFF_FIFO_STAT, 32'h0);
    check(rd & 32'h1100, 32'h1000);
    bus(1'b1, ssc_pkg::OFF_STEP_CTL, 32'h0000_0002);
    bus(1'b1, ssc_pkg::OFF_TRIGGER, 32'h1);
    wait_served(base + 8'h09);
    bus(1'b0, ssc_pkg::OFF_IRQ_STATUS, 32'h0);
    check(rd, 32'h2);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ssc_pkg::OFF_RESULT, 32'h0);
      check(rd, res(base + 8'(i), 1'b0, 1'b0, 2'h0));
    end
    bus(1'b0, ssc_pkg::OFF_FIFO_STAT, 32'h0);
    check(rd & 32'h1100, 32'h0100);
    $display("test full fifo done");
  endtask : t_full

  initial begin
    failures      = 0;
    cmp_count     = 0;
    rst           = 1'b1;
    slow          = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 8'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_seq;
    t_full;
    tally_and_finish;
  end
endmodule : sample_sequence_control_fifo_bench
`default_nettype wire
